// ### logic/ppm_map.svh
// Constants for the port policer and remarker: field positions, resets, timing.
// Assumes inclusion by the policer module only.
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
`define PPM_RATE_STEP_BPS   40000
`define PPM_CLK_HZ          250000000
`define PPM_TICK_NS         4
`define PPM_PREC_LSB        3
`define PPM_MTU_RESET       16'h05EE
`define PPM_TOK_W           32
`define PPM_CNT_W           32
`define PPM_COL_GREEN       2'h0
`define PPM_COL_YELLOW      2'h1
`define PPM_COL_RED         2'h2
`endif

// ### logic/ppm_pkg.sv
// Types for the port policer and remarker.
// Assumes ppm_map.svh is on the include path.
package ppm_pkg;
   typedef enum logic [1:0] {PPM_GREEN, PPM_YELLOW, PPM_RED} ppm_colour_e;
   // Packet descriptor seen at one policer stage
   typedef struct packed {
      logic [15:0] len;
      logic [5:0]  dscp;
      logic [2:0]  pcp;
      logic [2:0]  tc;
      logic        is_ctrl;
      logic        is_fcoe;
      logic        is_int_vlan;
      logic        is_l3_ctrl;
      logic        trapped;
      logic        acl_drop;
   } ppm_pkt_s;
   // Remark actions for one colour
   typedef struct packed {
      logic       set_dscp;
      logic [5:0] dscp;
      logic       set_prec;
      logic [2:0] prec;
      logic       set_tc;
      logic [2:0] tc;
      logic [2:0] pcp;
   } ppm_act_s;
   // Meter settings for one bucket
   typedef struct packed {
      logic [17:0] rate_steps;
      logic        burst_set;
      logic [31:0] burst;
   } ppm_meter_s;
endpackage

// ### logic/ppm_policer.sv
// Port policer and remarker: ingress and egress two-rate three-colour stages.
// Assumes packet descriptors arrive synchronous to ref_clk_in, one per valid.
// Functional notes
// - Green with DSCP rewrite takes the configured 6-bit DSCP.
// - Green with precedence rewrite replaces only the top three DSCP bits.
// - Green with queue assign takes the configured traffic class.
// - Yellow with DSCP rewrite takes the configured 6-bit DSCP.
// - Yellow with precedence rewrite replaces the precedence bits.
// - Yellow with queue assign takes the configured traffic class.
// - 802.1p priority comes from a per-colour priority map.
// - Policy without policing attributes marks all packets green.
// - Committed depth is at least twice the port MTU.
// - Unset burst depth is 1.2 times rate divided by eight.
// - No excess rate and no excess burst gives green or red only.
// - Rates are set in steps of 40000 bits per second.
// - Ingress and egress colour independently, colour-blind.
// - Control, storage and internal VLAN frames bypass metering.
// - Egress priority and DSCP remark override ingress results.
// - No policing on a fabric link port.
// - All drops except access-list drops are counted.
// - Layer 3 control packets are metered at egress.
// - Lossless priorities are metered at egress.
// - Trapped or dropped control traffic is not metered.
// - Flow-controlled priorities are excluded from port policing; flow-controlled lossless ones are still metered at egress.
// - Egress traffic class settings do not change forwarding.
// - Committed credits accrue up to burst and are spent on bursts.
// - Red packets are dropped with no remarking.
`timescale 1ns/1ns
`include "ppm_map.svh"
module ppm_policer
   import ppm_pkg::*;
#(
   parameter int TOK_W = `PPM_TOK_W,
   parameter int CNT_W = `PPM_CNT_W
) (
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             srst_in,
   // Port configuration
   input  wire logic             policy_attached_in,
   input  wire logic             fabric_link_port_in,
   input  wire logic [15:0]      port_mtu_in,
   input  wire logic [7:0]       pfc_enable_in,
   input  wire logic [7:0]       lossless_prio_in,
   // Per-stage meter settings, index 0 ingress, 1 egress
   input  wire logic [1:0]       has_police_attr_in,
   input  wire ppm_meter_s [1:0] cir_cfg_in,
   input  wire ppm_meter_s [1:0] eir_cfg_in,
   input  wire logic [1:0]       eir_set_in,
   input  wire ppm_act_s   [1:0] green_act_in,
   input  wire ppm_act_s   [1:0] yellow_act_in,
   // Packet stream in
   input  wire logic             pkt_valid_in,
   input  wire ppm_pkt_s         pkt_in,
   // Packet stream out
   output logic                  pkt_valid_out,
   output ppm_pkt_s              pkt_out,
   output logic                  pkt_drop_out,
   output logic [2:0]            fwd_tc_out,
   output ppm_colour_e [1:0]     colour_out,
   // Status
   output logic [CNT_W-1:0]      drop_count_out
);
   // ****************************************************************
   // Bucket depth and refill
   // ****************************************************************
   localparam logic [63:0] STEP = 64'(`PPM_RATE_STEP_BPS);
   localparam logic [63:0] CLK  = 64'(`PPM_CLK_HZ);

   logic [TOK_W-1:0] cdepth [2];
   logic [TOK_W-1:0] edepth [2];
   logic [31:0]      cinc   [2];
   logic [31:0]      einc   [2];
   logic [TOK_W-1:0] ctok_q [2];
   logic [TOK_W-1:0] ctok_d [2];
   logic [TOK_W-1:0] etok_q [2];
   logic [TOK_W-1:0] etok_d [2];
   logic [31:0]      cfrac_q [2];
   logic [31:0]      cfrac_d [2];
   logic [31:0]      efrac_q [2];
   logic [31:0]      efrac_d [2];
   ppm_colour_e      col [2];
   logic             metered [2];
   ppm_pkt_s         stage [3];
   logic             pkt_valid_q [3];
   logic             pkt_valid_d [3];
   logic             drop_q [3];
   logic             drop_d [3];

   // Depth from burst or rate; rate bytes per second is steps*40000/8
   function automatic logic [TOK_W-1:0] depth_of(input ppm_meter_s m, input logic [TOK_W-1:0] floor_v);
      logic [63:0] d;
      d = 64'h0;
      if (m.burst_set) begin
         d = 64'(m.burst);
      end else begin
         d = (64'(m.rate_steps) * STEP * 64'h0000_0000_0000_000C) / 64'h0000_0000_0000_0050;
      end
      if (d < 64'(floor_v)) begin
         d = 64'(floor_v);
      end
      return TOK_W'(d);
   endfunction

   // Per-stage meters; each stage colours with no reference to the other
   // colour-blind stages
   generate
      for (genvar s = 0; s < 2; s++) begin : g_stage
         logic exempt;
         logic [TOK_W-1:0] len;
         logic c_ok;
         logic e_ok;
         logic three_col;
         logic [63:0] csum;
         logic [63:0] esum;
         assign cdepth[s] = depth_of(cir_cfg_in[s], TOK_W'({port_mtu_in, 1'b0}));
         assign edepth[s] = depth_of(eir_cfg_in[s], TOK_W'(0));
         // rate step units; bytes per cycle kept as 16.16 fixed point
         assign cinc[s] = 32'((64'(cir_cfg_in[s].rate_steps) * STEP * 64'h1_0000) / (CLK * 64'h8));
         assign einc[s] = 32'((64'(eir_cfg_in[s].rate_steps) * STEP * 64'h1_0000) / (CLK * 64'h8));
         assign len = TOK_W'(stage[s].len);
         // bypass classes; L3 control and lossless metered only at egress
         always_comb begin
            exempt = stage[s].is_ctrl | stage[s].is_fcoe | stage[s].is_int_vlan | stage[s].trapped;
            exempt = exempt | (pfc_enable_in[stage[s].pcp] & ~lossless_prio_in[stage[s].pcp]);
            if (s == 0) begin
               exempt = exempt | stage[s].is_l3_ctrl | lossless_prio_in[stage[s].pcp];
            end else if (stage[s].is_l3_ctrl) begin
               exempt = stage[s].trapped;
            end
            metered[s] = policy_attached_in & ~fabric_link_port_in & has_police_attr_in[s] & ~exempt;
         end
         // committed first, then excess; two-colour without excess
         always_comb begin
            three_col = eir_set_in[s];
            c_ok = ctok_q[s] >= len;
            e_ok = three_col & (etok_q[s] >= len);
            if (!metered[s] || c_ok) begin
               col[s] = PPM_GREEN;
            end else if (e_ok) begin
               col[s] = PPM_YELLOW;
            end else begin
               col[s] = PPM_RED;
            end
         end
         // credit accrual capped at depth, spent on acceptance
         always_comb begin
            csum = 64'(cfrac_q[s]) + 64'({cinc[s][15:0], 16'h0});
            esum = 64'(efrac_q[s]) + 64'({einc[s][15:0], 16'h0});
            cfrac_d[s] = csum[31:0];
            efrac_d[s] = esum[31:0];
            ctok_d[s] = ctok_q[s] + TOK_W'(cinc[s] >> 16) + TOK_W'(csum[32]);
            etok_d[s] = etok_q[s] + TOK_W'(einc[s] >> 16) + TOK_W'(esum[32]);
            // Packets already dropped upstream spend no credit
            if (pkt_valid_q[s] && !drop_q[s] && metered[s] && col[s] == PPM_GREEN) begin
               ctok_d[s] = ctok_d[s] - len;
            end
            if (pkt_valid_q[s] && !drop_q[s] && metered[s] && col[s] == PPM_YELLOW) begin
               etok_d[s] = etok_d[s] - len;
            end
            if (ctok_d[s] > cdepth[s]) begin
               ctok_d[s] = cdepth[s];
            end
            if (etok_d[s] > edepth[s] || !three_col) begin
               etok_d[s] = three_col ? edepth[s] : TOK_W'(0);
            end
         end
         always_ff @(posedge ref_clk_in) begin
            if (srst_in) begin
               ctok_q[s]  <= '0;
               etok_q[s]  <= '0;
               cfrac_q[s] <= '0;
               efrac_q[s] <= '0;
            end else begin
               ctok_q[s]  <= ctok_d[s];
               etok_q[s]  <= etok_d[s];
               cfrac_q[s] <= cfrac_d[s];
               efrac_q[s] <= efrac_d[s];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Pipeline: input, ingress stage, egress stage
   // ****************************************************************
   ppm_pkt_s    stage_q [3];
   ppm_pkt_s    stage_d [3];
   ppm_colour_e col_q [2];
   ppm_colour_e col_d [2];
   logic [2:0]  fwd_tc_q;
   logic [2:0]  fwd_tc_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   assign stage[0] = stage_q[0];
   assign stage[1] = stage_q[1];
   assign stage[2] = stage_q[2];

   // Apply actions of one colour to a descriptor
   function automatic ppm_pkt_s remark(input ppm_pkt_s p, input ppm_act_s a);
      ppm_pkt_s r;
      r = p;
      if (a.set_dscp) begin
         r.dscp = a.dscp;
      end
      if (a.set_prec) begin
         r.dscp = {a.prec, r.dscp[`PPM_PREC_LSB-1:0]};
      end
      if (a.set_tc) begin
         r.tc = a.tc;
      end
      r.pcp = a.pcp;
      return r;
   endfunction

   // Next pipeline values; egress remark lands last so it overrides ingress
   always_comb begin
      pkt_valid_d[0] = pkt_valid_in;
      stage_d[0]     = pkt_in;
      drop_d[0]      = pkt_in.acl_drop;
      for (int s = 0; s < 2; s++) begin
         pkt_valid_d[s+1] = pkt_valid_q[s];
         drop_d[s+1]      = drop_q[s];
         stage_d[s+1]     = stage_q[s];
         col_d[s]         = col[s];
         // red dropped, no remark; later stage overrides
         if (!drop_q[s] && metered[s]) begin
            unique case (col[s])
               PPM_GREEN:  stage_d[s+1] = remark(stage_q[s], green_act_in[s]);
               PPM_YELLOW: stage_d[s+1] = remark(stage_q[s], yellow_act_in[s]);
               PPM_RED:    drop_d[s+1]  = 1'b1;
            endcase
         end
      end
      // forwarding queue fixed by ingress result
      fwd_tc_d = pkt_valid_q[1] ? stage_q[1].tc : fwd_tc_q;
      cnt_d = cnt_q;
      if (pkt_valid_q[2] && drop_q[2] && !stage_q[2].acl_drop) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < 3; i++) begin
            pkt_valid_q[i] <= 1'b0;
            drop_q[i]      <= 1'b0;
            stage_q[i]     <= '0;
         end
         col_q[0] <= PPM_GREEN;
         col_q[1] <= PPM_GREEN;
         fwd_tc_q <= 3'h0;
         cnt_q    <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            pkt_valid_q[i] <= pkt_valid_d[i];
            drop_q[i]      <= drop_d[i];
            stage_q[i]     <= stage_d[i];
         end
         col_q[0] <= col_d[0];
         col_q[1] <= col_d[1];
         fwd_tc_q <= fwd_tc_d;
         cnt_q    <= cnt_d;
      end
   end

   // Outputs from flip-flops
   assign pkt_valid_out  = pkt_valid_q[2];
   assign pkt_out        = stage_q[2];
   assign pkt_drop_out   = drop_q[2];
   assign fwd_tc_out     = fwd_tc_q;
   assign colour_out[0]  = col_q[0];
   assign colour_out[1]  = col_q[1];
   assign drop_count_out = cnt_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence red_seen;
      pkt_valid_q[0] && metered[0] && !drop_q[0] && col[0] == PPM_RED;
   endsequence
   chk_red_drop_count: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      red_seen |=> ##1 (pkt_drop_out && !pkt_out.acl_drop) ##1 drop_count_out == $past(drop_count_out) + CNT_W'(1))
      else $error("red drop not counted");
   chk_red_no_remark: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      red_seen |=> ##1 pkt_drop_out && pkt_out == $past(stage_q[0], 2))
      else $error("red packet remarked");
   chk_ctok_cap: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ctok_q[0] <= cdepth[0] || $changed(cdepth[0]))
      else $error("committed tokens above depth");
   chk_no_attr_green: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !has_police_attr_in[0] |-> col[0] == PPM_GREEN)
      else $error("no attributes yet not green");
   chk_fabric_green: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      fabric_link_port_in |-> col[0] == PPM_GREEN && col[1] == PPM_GREEN)
      else $error("fabric link policed");
   chk_two_colour: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !eir_set_in[0] |-> col[0] != PPM_YELLOW)
      else $error("yellow without excess bucket");
   chk_mtu_floor: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      cdepth[0] >= TOK_W'({port_mtu_in, 1'b0}))
      else $error("committed depth under twice MTU");
   chk_egress_dscp: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (pkt_valid_q[1] && metered[1] && !drop_q[1] && col[1] == PPM_GREEN && green_act_in[1].set_dscp
       && !green_act_in[1].set_prec) |=> pkt_out.dscp == $past(green_act_in[1].dscp))
      else $error("egress DSCP not applied");
   chk_ctrl_bypass: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      stage_q[0].is_ctrl |-> !metered[0])
      else $error("control frame metered");
endmodule

// ### sim/port_policer_marker_tb.sv
// Self-checking bench for the port policer and remarker.
// Assumes ppm_src as the datapath model and ppm_map.svh on the include path.
`timescale 1ns/1ns
module port_policer_marker_tb
   import ppm_pkg::*;
;
   // ******************************
   // Stimulus, model and checks
   // ******************************
   logic              ref_clk, srst, fab_link, pol, vld_in, vld_out, drop_out;
   logic [7:0]        pfc;
   logic [1:0]        attr, eir_set;
   logic [2:0]        ftc;
   logic [31:0]       drop_cnt;
   ppm_meter_s [1:0]  cir, eir;
   ppm_act_s   [1:0]  gact, yact;
   ppm_pkt_s          p_in, p_out, tmpl;
   ppm_colour_e [1:0] col;
   int                errors, num_checks, exp_drops;
   ppm_policer u_dut (.ref_clk_in(ref_clk), .srst_in(srst), .policy_attached_in(pol),
      .fabric_link_port_in(fab_link), .port_mtu_in(16'h05DC), .pfc_enable_in(pfc),
      .lossless_prio_in(8'h00), .has_police_attr_in(attr), .cir_cfg_in(cir), .eir_cfg_in(eir),
      .eir_set_in(eir_set), .green_act_in(gact), .yellow_act_in(yact), .pkt_valid_in(vld_in),
      .pkt_in(p_in), .pkt_valid_out(vld_out), .pkt_out(p_out), .pkt_drop_out(drop_out),
      .fwd_tc_out(ftc), .colour_out(col), .drop_count_out(drop_cnt));
   ppm_src u_src (.ref_clk_in(ref_clk), .pkt_valid_out(vld_in), .pkt_out(p_in),
      .pkt_valid_in(vld_out), .pkt_in(p_out), .pkt_drop_in(drop_out), .fwd_tc_in(ftc));
   // 250 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Precedence applied after DSCP, so only one is enabled at a time
   function automatic ppm_pkt_s rmk(ppm_pkt_s p, ppm_act_s a);
      if (a.set_dscp) p.dscp = a.dscp;
      if (a.set_prec) p.dscp[5:3] = a.prec;
      if (a.set_tc) p.tc = a.tc;
      p.pcp = a.pcp;
      return p;
   endfunction
   // Kind k: 0 green, 1 yellow, 2 red, 3 bypass, 4 access-list drop
   task automatic take(ppm_pkt_s p, int k);
      ppm_pkt_s q;
      logic [2:0] t;
      for (int i = 0; i < 20 && u_src.d_q.size() == 0; i++) @(negedge ref_clk);
      if (u_src.d_q.size() == 0) begin
         errors++;
         $display("BAD result exp 1 seen 0");
         return;
      end
      // Only a stage with policing attributes remarks; egress always colours green here
      q = p;
      if (k < 2 && attr[0]) q = rmk(p, k == 0 ? gact[0] : yact[0]);
      t = q.tc;
      if (k < 2 && attr[1]) q = rmk(q, gact[1]);
      chk("drop", u_src.d_q.pop_front(), k == 2 || k == 4);
      chk("dscp", u_src.p_q[0].dscp, q.dscp);
      chk("pcp", u_src.p_q[0].pcp, q.pcp);
      if (k < 2) chk("fwd_tc", u_src.t_q[0], t);
      void'(u_src.t_q.pop_front());
      void'(u_src.p_q.pop_front());
      if (k == 2) exp_drops++;
   endtask
   // n random packets back to back, the last one of kind kl
   task automatic go(int n, int k, int kl);
      ppm_pkt_s s[$];
      ppm_pkt_s p;
      for (int i = 0; i < n; i++) begin
         p = tmpl;
         p.dscp = 6'($urandom);
         p.pcp = 3'($urandom);
         p.tc = 3'($urandom);
         s.push_back(p);
         u_src.send(p);
      end
      u_src.idle();
      foreach (s[i]) take(s[i], i == n - 1 ? kl : k);
   endtask
   // One ingress action kind enabled, values random
   task automatic acts(int m);
      gact[0] = {m == 0, 6'($urandom), m == 1, 3'($urandom), m == 2, 3'($urandom), 3'($urandom)};
      yact[0] = {m == 0, 6'($urandom), m == 1, 3'($urandom), m == 2, 3'($urandom), 3'($urandom)};
   endtask
   // Reset empties the buckets, then a long gap lets them refill
   task automatic setup(logic [1:0] at, logic [17:0] cr, logic cb, logic [17:0] er, logic es);
      @(negedge ref_clk);
      attr = at;
      cir[0] = {cr, cb, 32'h00000064};
      eir[0] = {er, 1'h0, 32'h00000000};
      eir_set = {1'h0, es};
      srst = 1'h1;
      repeat (2) @(negedge ref_clk);
      srst = 1'h0;
      repeat (1000) @(negedge ref_clk);
      exp_drops = 0;
   endtask
   task automatic fin(string nm);
      repeat (4) @(negedge ref_clk);
      chk("drop_count", drop_cnt, exp_drops);
      $display("test %s done", nm);
   endtask
   initial begin
      #60000;
      errors++;
      $display("BAD watchdog exp done seen hang");
      conclude();
   end
   initial begin
      srst = 1'h1;
      fab_link = 1'h0;
      pol = 1'h1;
      pfc = 8'h00;
      attr = 2'h0;
      eir_set = 2'h0;
      cir = '0;
      // Egress committed at full rate, so egress stays green and its remark shows
      cir[1] = {18'h3FFFF, 1'h0, 32'h00000000};
      eir = '0;
      gact = '0;
      yact = '0;
      gact[1] = {1'h0, 6'h00, 1'h0, 3'h0, 1'h1, 3'h7, 3'h5};
      tmpl = '0;
      tmpl.len = 16'h0040;
      repeat (10) @(negedge ref_clk);
      srst = 1'h0;
      chk("valid_rst", vld_out, 1'h0);
      chk("count_rst", drop_cnt, 32'h0);
      void'($urandom(78200));
      // no policing attributes, zero rates, all green
      setup(2'h0, 18'h0, 1'h0, 18'h0, 1'h0);
      acts(0);
      go(6, 0, 0);
      fin("no_attr");
      // two-colour with no credit: red, dropped
      setup(2'h3, 18'h0, 1'h1, 18'h0, 1'h0);
      go(4, 2, 2);
      tmpl.acl_drop = 1'h1;
      go(1, 4, 4);
      tmpl.acl_drop = 1'h0;
      fin("red");
      for (int f = 0; f < 6; f++) begin
         tmpl.is_ctrl = f == 0;
         tmpl.is_fcoe = f == 1;
         tmpl.is_int_vlan = f == 2;
         fab_link = f == 3;
         pol = f != 4;
         pfc = f == 5 ? 8'hFF : 8'h00;
         go(2, 3, 3);
      end
      tmpl = '0;
      tmpl.len = 16'h0040;
      fab_link = 1'h0;
      pol = 1'h1;
      pfc = 8'h00;
      fin("bypass");
      setup(2'h3, 18'h3FFFF, 1'h0, 18'h0, 1'h0);
      for (int m = 0; m < 3; m++) begin
         acts(m);
         go(4, 0, 0);
      end
      fin("green");
      setup(2'h3, 18'h0, 1'h1, 18'h3FFFF, 1'h1);
      for (int m = 0; m < 3; m++) begin
         acts(m);
         go(4, 1, 1);
      end
      fin("yellow");
      // depth floored at twice MTU: two big packets fit, the third does not
      setup(2'h3, 18'h3FFFF, 1'h1, 18'h0, 1'h0);
      // Egress DSCP rewrite now overrides the ingress DSCP of green packets
      gact[1].set_dscp = 1'h1;
      gact[1].dscp = 6'h2A;
      tmpl.len = 16'h0578;
      go(3, 0, 2);
      fin("burst");
      conclude();
   end
endmodule

// ### sim/ppm_src.sv
// Switch datapath model: offers packet descriptors to the policer, collects results.
// Assumes one caller of send and idle, stepping on the falling edge.
`timescale 1ns/1ns
module ppm_src
   import ppm_pkg::*;
(
   // Clock
   input  wire logic       ref_clk_in,
   // Toward the policer
   output logic            pkt_valid_out,
   output ppm_pkt_s        pkt_out,
   // From the policer
   input  wire logic       pkt_valid_in,
   input  wire ppm_pkt_s   pkt_in,
   input  wire logic       pkt_drop_in,
   input  wire logic [2:0] fwd_tc_in
);
   // ******************************
   // Offer and capture
   // ******************************
   logic       d_q[$];
   logic [2:0] t_q[$];
   ppm_pkt_s   p_q[$];
   initial begin
      pkt_valid_out = 1'h0;
      pkt_out = '0;
   end
   // One descriptor per falling edge, so back-to-back offers are possible
   task automatic send(ppm_pkt_s p);
      @(negedge ref_clk_in);
      pkt_valid_out = 1'h1;
      pkt_out = p;
   endtask
   // Idle bus shows inverted junk, never the last descriptor
   task automatic idle();
      @(negedge ref_clk_in);
      pkt_valid_out = 1'h0;
      pkt_out = ~pkt_out;
   endtask
   // Sampled mid-cycle, well clear of the registered outputs
   always @(negedge ref_clk_in) begin
      if (pkt_valid_in === 1'h1) begin
         d_q.push_back(pkt_drop_in);
         t_q.push_back(fwd_tc_in);
         p_q.push_back(pkt_in);
      end
   end
endmodule
